// ==== otp_bank_cfg.svh ====
`ifndef OTP_BANK_CFG_SVH
`define OTP_BANK_CFG_SVH
// Register indices; byte address is four times the index
`define IX_LOCK 16'h0000
`define IX_OVR 16'h0007
`define IX_FLOW 16'h0008
`define IX_PFN 16'h0009
`define IX_ARM 16'h1898
// Extra registers, byte addresses
`define A_COMMIT 16'h7000
`define A_STATUS 16'h7004
`define ARM_KEY 8'h10
// Field positions
`define B_LOCK 6
`define B_THR 4
`define B_MASK 3
`define B_DIR 2
`define B_PFN 1
`define B_FLOW 0
`define B_HDX 3
`define B_CLK 7
`define B_SEL 4
`define B_POL 3
`define B_COMMIT 0
// Bus answers and reset values
`define RESP_OK 2'b00
`define RESP_SLV 2'b10
`define RESP_DEC 2'b11
`define RST_BYTE 8'h00
`define RST_HALF 16'h0000
`define RST_WORD 32'h0000_0000
`endif

// ==== otp_bank_pkg.sv ====
package otp_bank_pkg;
	typedef enum logic [2:0] {FM_NONE = 3'b000, FM_HW = 3'b001, FM_SW = 3'b010, FM_MD_RX = 3'b011,
		FM_MD_ALL = 3'b100} flow_mode_t;
	typedef enum logic [2:0] {PM_GPIO = 3'b000, PM_RTS_CTS = 3'b001, PM_DTR_DSR = 3'b010,
		PM_DE_TX = 3'b011, PM_DE_MATCH = 3'b100} pin_mode_t;
	typedef enum logic [1:0] {RS_GPIO = 2'b00, RS_TX = 2'b01, RS_MATCH = 2'b10, RS_RSVD = 2'b11} rs_sel_t;
	typedef struct packed {
		logic awvalid;
		logic [15:0] awaddr;
		logic [2:0] awprot;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [15:0] araddr;
		logic [2:0] arprot;
		logic rready;
	} axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;
	typedef struct packed {
		logic tx_busy;
		logic addr_match;
	} link_in_t;
	typedef struct packed {
		logic rx_en;
		logic tx_en;
		logic hw_flow;
		logic sw_flow;
		logic match_en;
		logic pins45_rts_cts;
		logic pins23_dtr_dsr;
		logic pin6_clk;
		logic pin5_de_fn;
		logic pin5_de;
		logic pin7_de_fn;
		logic pin7_de;
		logic use_thresh;
		logic use_mask;
		logic use_dir;
		logic lock_active;
	} ctl_out_t;
	typedef struct packed {
		axi_rsp_t rsp;
		logic aw_have;
		logic [15:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [7:0] cell_lock;
		logic [7:0] cell_ovr;
		logic [15:0] cell_flow;
		logic [7:0] cell_pfn;
		logic commit;
		logic [7:0] arm;
		logic lock_eff;
		logic [7:0] ovr_eff;
		logic [15:0] flow_eff;
		logic [7:0] pfn_eff;
		ctl_out_t out;
	} state_t;
endpackage

// ==== otp_uart_default_override.sv ====
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "otp_bank_cfg.svh"
module otp_uart_default_override #(
	parameter logic [15:0] DEF_FLOW = 16'h0000,
	parameter logic [7:0] DEF_PFN = 8'h00,
	parameter logic [7:0] FACTORY_CFG = 8'h00
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic otp_clear,
	input wire otp_bank_pkg::axi_req_t axi,
	output otp_bank_pkg::axi_rsp_t axi_rsp,
	input wire otp_bank_pkg::link_in_t link,
	output otp_bank_pkg::ctl_out_t ctl
);
	// ****************************************
	// Address map
	// ****************************************
	localparam logic [15:0] A_LOCK = `IX_LOCK << 2;
	localparam logic [15:0] A_OVR = `IX_OVR << 2;
	localparam logic [15:0] A_FLOW = `IX_FLOW << 2;
	localparam logic [15:0] A_PFN = `IX_PFN << 2;
	localparam logic [15:0] A_ARM = `IX_ARM << 2;

	otp_bank_pkg::state_t state_q;
	otp_bank_pkg::state_t state_d;
	logic wr_fire;
	logic wr_otp;
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] lock_v;
	logic [7:0] flow_v;
	logic [7:0] pfn_v;
	logic as5;
	logic as7;
	otp_bank_pkg::flow_mode_t fm;
	otp_bank_pkg::pin_mode_t pm;
	otp_bank_pkg::rs_sel_t rs;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		b0 = state_q.wstrb[0] ? state_q.wdata[7:0] : `RST_BYTE;
		b1 = state_q.wstrb[1] ? state_q.wdata[15:8] : `RST_BYTE;
		lock_v = b0;
		wr_fire = state_q.aw_have && state_q.w_have && !state_q.rsp.bvalid;
		wr_otp = (state_q.awaddr == A_LOCK) || (state_q.awaddr == A_OVR) || (state_q.awaddr == A_FLOW)
			|| (state_q.awaddr == A_PFN) || (state_q.awaddr == `A_COMMIT);
		// Write response retires
		if (state_q.rsp.bvalid && axi.bready)
		begin
			state_d.rsp.bvalid = 1'b0;
		end
		// Address and data taken in either order
		if (axi.awvalid && state_q.rsp.awready)
		begin
			state_d.aw_have = 1'b1;
			state_d.awaddr = axi.awaddr;
		end
		if (axi.wvalid && state_q.rsp.wready)
		begin
			state_d.w_have = 1'b1;
			state_d.wdata = axi.wdata;
			state_d.wstrb = axi.wstrb;
		end
		// Programming: cells only ever gain ones
		if (wr_fire)
		begin
			state_d.aw_have = 1'b0;
			state_d.w_have = 1'b0;
			state_d.rsp.bvalid = 1'b1;
			state_d.rsp.bresp = `RESP_OK;
			if (wr_otp && state_q.lock_eff)
			begin
				state_d.rsp.bresp = `RESP_SLV;
			end
			else
			begin
				unique case (state_q.awaddr)
					A_LOCK:
					begin
						if (state_q.commit)
						begin
							state_d.rsp.bresp = `RESP_SLV;
						end
						else
						begin
							if (state_q.arm != `ARM_KEY)
							begin
								lock_v[`B_LOCK] = 1'b0;
							end
							state_d.cell_lock = state_q.cell_lock | lock_v;
						end
					end
					A_OVR: state_d.cell_ovr = state_q.cell_ovr | b0;
					A_FLOW: state_d.cell_flow = state_q.cell_flow | {b1, b0};
					A_PFN: state_d.cell_pfn = state_q.cell_pfn | b0;
					`A_COMMIT: state_d.commit = state_q.commit | b0[`B_COMMIT];
					A_ARM: state_d.arm = b0;
					`A_STATUS: state_d.rsp.bresp = `RESP_OK;
					default: state_d.rsp.bresp = `RESP_DEC;
				endcase
			end
		end
		state_d.rsp.awready = !state_d.aw_have && !state_d.rsp.bvalid;
		state_d.rsp.wready = !state_d.w_have && !state_d.rsp.bvalid;
		// Read channel, one outstanding
		if (state_q.rsp.rvalid && axi.rready)
		begin
			state_d.rsp.rvalid = 1'b0;
		end
		if (axi.arvalid && state_q.rsp.arready)
		begin
			state_d.rsp.rvalid = 1'b1;
			state_d.rsp.rresp = `RESP_OK;
			state_d.rsp.rdata = `RST_WORD;
			unique case (axi.araddr)
				A_LOCK: state_d.rsp.rdata[7:0] = state_q.cell_lock;
				A_OVR: state_d.rsp.rdata[7:0] = state_q.cell_ovr;
				A_FLOW: state_d.rsp.rdata[15:0] = state_q.cell_flow;
				A_PFN: state_d.rsp.rdata[7:0] = state_q.cell_pfn;
				`A_COMMIT: state_d.rsp.rdata[`B_COMMIT] = state_q.commit;
				A_ARM: state_d.rsp.rdata[7:0] = state_q.arm;
				`A_STATUS: state_d.rsp.rdata[`B_COMMIT] = state_q.lock_eff;
				default: state_d.rsp.rresp = `RESP_DEC;
			endcase
		end
		state_d.rsp.arready = !state_d.rsp.rvalid;
		// Operating controls from loaded settings
		fm = otp_bank_pkg::flow_mode_t'(state_q.flow_eff[2:0]);
		pm = otp_bank_pkg::pin_mode_t'(state_q.pfn_eff[2:0]);
		rs = otp_bank_pkg::rs_sel_t'(state_q.pfn_eff[6:5]);
		flow_v = state_q.flow_eff[7:0];
		pfn_v = state_q.pfn_eff;
		state_d.out.match_en = (fm == otp_bank_pkg::FM_MD_RX) || (fm == otp_bank_pkg::FM_MD_ALL);
		state_d.out.rx_en = !(flow_v[`B_HDX] && link.tx_busy)
			&& (!state_d.out.match_en || link.addr_match);
		state_d.out.tx_en = (fm != otp_bank_pkg::FM_MD_ALL) || link.addr_match;
		state_d.out.hw_flow = fm == otp_bank_pkg::FM_HW;
		state_d.out.sw_flow = fm == otp_bank_pkg::FM_SW;
		state_d.out.pins45_rts_cts = pm == otp_bank_pkg::PM_RTS_CTS;
		state_d.out.pins23_dtr_dsr = pm == otp_bank_pkg::PM_DTR_DSR;
		state_d.out.pin6_clk = pfn_v[`B_CLK];
		// Direction enables, level set by polarity
		state_d.out.pin5_de_fn = (pm == otp_bank_pkg::PM_DE_TX) || (pm == otp_bank_pkg::PM_DE_MATCH);
		as5 = ((pm == otp_bank_pkg::PM_DE_TX) && link.tx_busy)
			|| ((pm == otp_bank_pkg::PM_DE_MATCH) && link.addr_match);
		state_d.out.pin5_de = state_d.out.pin5_de_fn && (as5 ^ pfn_v[`B_POL]);
		state_d.out.pin7_de_fn = pfn_v[`B_SEL] && ((rs == otp_bank_pkg::RS_TX) || (rs == otp_bank_pkg::RS_MATCH));
		as7 = ((rs == otp_bank_pkg::RS_TX) && link.tx_busy)
			|| ((rs == otp_bank_pkg::RS_MATCH) && link.addr_match);
		state_d.out.pin7_de = state_d.out.pin7_de_fn && (as7 ^ pfn_v[`B_POL]);
		state_d.out.use_thresh = state_q.ovr_eff[`B_THR];
		state_d.out.use_mask = state_q.ovr_eff[`B_MASK];
		state_d.out.use_dir = state_q.ovr_eff[`B_DIR];
		state_d.out.lock_active = state_q.lock_eff;
		// Blank array with factory byte
		if (otp_clear)
		begin
			state_d.cell_lock = FACTORY_CFG;
			state_d.cell_ovr = `RST_BYTE;
			state_d.cell_flow = `RST_HALF;
			state_d.cell_pfn = `RST_BYTE;
			state_d.commit = 1'b0;
		end
		// Reset: bus idle, cells loaded into operation
		if (rst)
		begin
			state_d.rsp = '0;
			state_d.aw_have = 1'b0;
			state_d.awaddr = `RST_HALF;
			state_d.w_have = 1'b0;
			state_d.wdata = `RST_WORD;
			state_d.wstrb = '0;
			state_d.arm = `RST_BYTE;
			state_d.out = '0;
			state_d.lock_eff = state_d.commit && state_d.cell_lock[`B_LOCK];
			state_d.ovr_eff = state_d.cell_ovr;
			state_d.flow_eff = state_d.cell_ovr[`B_FLOW] ? state_d.cell_flow : DEF_FLOW;
			state_d.pfn_eff = state_d.cell_ovr[`B_PFN] ? state_d.cell_pfn : DEF_PFN;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		state_q <= state_d;
	end

	assign axi_rsp = state_q.rsp;
	assign ctl = state_q.out;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_wr_ready;
		state_q.aw_have && state_q.w_have && !state_q.rsp.bvalid;
	endsequence
	sequence s_wr_answer;
		state_q.rsp.bvalid && !state_q.aw_have && !state_q.w_have;
	endsequence
	property p_wr_resp;
		@(posedge clk) disable iff (rst) s_wr_ready |=> s_wr_answer;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");

	property p_lock_hold;
		@(posedge clk) disable iff (rst || otp_clear) state_q.lock_eff |=> $stable(state_q.cell_lock)
			&& $stable(state_q.cell_ovr) && $stable(state_q.cell_flow) && $stable(state_q.cell_pfn);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("cell changed under lock");

	property p_lock_late;
		@(posedge clk) disable iff (rst) !$past(rst) |-> $stable(state_q.lock_eff);
	endproperty
	a_lock_late: assert property (p_lock_late) else $error("lock changed outside reset");

	property p_set_only;
		@(posedge clk) disable iff (rst || otp_clear) ##1 ($past(state_q.cell_flow) & ~state_q.cell_flow) == `RST_HALF;
	endproperty
	a_set_only: assert property (p_set_only) else $error("programmed bit cleared");

	property p_flow_load;
		@(posedge clk) disable iff (rst) $past(rst) |->
			state_q.flow_eff == (state_q.cell_ovr[`B_FLOW] ? state_q.cell_flow : DEF_FLOW);
	endproperty
	a_flow_load: assert property (p_flow_load) else $error("flow setting not loaded");

	property p_pfn_load;
		@(posedge clk) disable iff (rst) $past(rst) |->
			state_q.pfn_eff == (state_q.cell_ovr[`B_PFN] ? state_q.cell_pfn : DEF_PFN);
	endproperty
	a_pfn_load: assert property (p_pfn_load) else $error("pin function not loaded");

	property p_half_dup;
		@(posedge clk) disable iff (rst) state_q.flow_eff[`B_HDX] && link.tx_busy |=> !state_q.out.rx_en;
	endproperty
	a_half_dup: assert property (p_half_dup) else $error("receive open while sending");

	property p_md_all;
		@(posedge clk) disable iff (rst) (state_q.flow_eff[2:0] == otp_bank_pkg::FM_MD_ALL) && !link.addr_match
			|=> !state_q.out.tx_en && !state_q.out.rx_en;
	endproperty
	a_md_all: assert property (p_md_all) else $error("multidrop gate open");

	// Outputs are cleared by the reset edge, so attempts start only on non-reset edges
	property p_clk_out;
		@(posedge clk) disable iff (rst) !rst |=> state_q.out.pin6_clk == $past(state_q.pfn_eff[`B_CLK]);
	endproperty
	a_clk_out: assert property (p_clk_out) else $error("clock pin select wrong");

	property p_pin7_tx;
		@(posedge clk) disable iff (rst) !rst && state_q.pfn_eff[`B_SEL]
			&& (state_q.pfn_eff[6:5] == otp_bank_pkg::RS_TX) && link.tx_busy
			|=> state_q.out.pin7_de == !state_q.pfn_eff[`B_POL];
	endproperty
	a_pin7_tx: assert property (p_pin7_tx) else $error("pin seven enable wrong");

	property p_commit;
		@(posedge clk) disable iff (rst || otp_clear) state_q.commit |=> $stable(state_q.cell_lock);
	endproperty
	a_commit: assert property (p_commit) else $error("committed field changed");

	// Lock bit write without the key leaves the bit as it was
	property p_arm_gate;
		@(posedge clk) disable iff (rst || otp_clear) state_q.aw_have && state_q.w_have && !state_q.rsp.bvalid
			&& (state_q.awaddr == A_LOCK) && (state_q.arm != `ARM_KEY)
			|=> state_q.cell_lock[`B_LOCK] == $past(state_q.cell_lock[`B_LOCK]);
	endproperty
	a_arm_gate: assert property (p_arm_gate) else $error("lock bit taken without key");

	property p_pin5_tx;
		@(posedge clk) disable iff (rst) !rst && (state_q.pfn_eff[2:0] == otp_bank_pkg::PM_DE_TX) && link.tx_busy
			|=> state_q.out.pin5_de == !state_q.pfn_eff[`B_POL];
	endproperty
	a_pin5_tx: assert property (p_pin5_tx) else $error("pin five enable wrong");

	property p_hw_flow;
		@(posedge clk) disable iff (rst) !rst && (state_q.flow_eff[2:0] == otp_bank_pkg::FM_HW) |=> state_q.out.hw_flow;
	endproperty
	a_hw_flow: assert property (p_hw_flow) else $error("hardware flow not enabled");

	property p_rd_resp;
		@(posedge clk) disable iff (rst) axi.arvalid && state_q.rsp.arready |=> state_q.rsp.rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
`include "otp_bank_cfg.svh"
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic otp_clear = 1'b1;
	otp_bank_pkg::axi_req_t req = '0;
	otp_bank_pkg::axi_rsp_t rsp;
	otp_bank_pkg::link_in_t link = '0;
	otp_bank_pkg::ctl_out_t ctl;
	int errors = 0;
	int checks_done = 0;
	logic [1:0] r;
	logic [31:0] d;
	logic [7:0] ov;
	logic [7:0] pf;
	logic [15:0] fl;
	logic [15:0] ra [4];

	// Clock at 100 MHz
	always #5 clk = ~clk;

	otp_uart_default_override dut (
		.clk(clk),
		.rst(rst),
		.otp_clear(otp_clear),
		.axi(req),
		.axi_rsp(rsp),
		.link(link),
		.ctl(ctl)
	);

	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Reset, optionally blanking the cells first
	task automatic power(input logic clr);
		@(posedge clk);
		rst <= 1'b1;
		otp_clear <= clr;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		otp_clear <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
		end
		while (rsp.bvalid !== 1'b1 && n < 50);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		chk(32'(n < 50), 32'h1);
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
		end
		while (rsp.rvalid !== 1'b1 && n < 50);
		v = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		chk(32'(n < 50), 32'h1);
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask

	task automatic wchk(input logic [15:0] a, input logic [31:0] v, input logic [1:0] er);
		wr(a, v, r);
		chk(32'(r), 32'(er));
	endtask

	// Expected control outputs from loaded settings and link state
	function automatic otp_bank_pkg::ctl_out_t want(input logic [7:0] o, input logic [15:0] f0,
		input logic [7:0] p0, input logic lk, input otp_bank_pkg::link_in_t ln);
		otp_bank_pkg::ctl_out_t c;
		logic [15:0] f;
		logic [7:0] p;
		logic md;
		f = o[0] ? f0 : 16'h0000;
		p = o[1] ? p0 : 8'h00;
		md = f[2:0] == 3'b011 || f[2:0] == 3'b100;
		c = '0;
		c.rx_en = (!md || ln.addr_match) && !(f[3] && ln.tx_busy);
		c.tx_en = f[2:0] != 3'b100 || ln.addr_match;
		c.hw_flow = f[2:0] == 3'b001;
		c.sw_flow = f[2:0] == 3'b010;
		c.match_en = md;
		c.pins45_rts_cts = p[2:0] == 3'b001;
		c.pins23_dtr_dsr = p[2:0] == 3'b010;
		c.pin6_clk = p[7];
		c.pin5_de_fn = p[2:0] == 3'b011 || p[2:0] == 3'b100;
		c.pin5_de = c.pin5_de_fn && ((p[2:0] == 3'b011 ? ln.tx_busy : ln.addr_match) ^ p[3]);
		c.pin7_de_fn = p[4] && (p[6:5] == 2'b01 || p[6:5] == 2'b10);
		c.pin7_de = c.pin7_de_fn && ((p[6:5] == 2'b01 ? ln.tx_busy : ln.addr_match) ^ p[3]);
		c.use_thresh = o[4];
		c.use_mask = o[3];
		c.use_dir = o[2];
		c.lock_active = lk;
		return c;
	endfunction

	// Walk all link states and compare the control outputs
	task automatic lchk(input logic lk);
		for (int j = 0; j < 4; j++)
		begin
			link <= otp_bank_pkg::link_in_t'(j[1:0]);
			repeat (2) @(posedge clk);
			chk(32'(ctl), 32'(want(ov, fl, pf, lk, link)));
		end
	endtask

	// ****
	// Tests
	// ****
	initial
	begin
		void'($urandom(20));
		ra = '{`IX_LOCK << 2, `IX_OVR << 2, `IX_FLOW << 2, `IX_PFN << 2};
		ov = 8'h00;
		fl = 16'h0000;
		pf = 8'h00;
		power(1'b1);
		foreach (ra[k])
			rchk(ra[k], 32'h0, `RESP_OK);
		rchk(`A_STATUS, 32'h0, `RESP_OK);
		rchk(16'h0100, 32'h0, `RESP_DEC);
		wchk(16'h0100, 32'h1, `RESP_DEC);
		lchk(1'b0);
		$display("test blank done");
		for (int i = 0; i < 12; i++)
		begin
			ov = {3'b000, 5'($urandom)} | (i < 5 ? 8'h03 : 8'h00);
			fl = {12'h000, 1'($urandom), (i < 5 ? 3'(i) : 3'($urandom_range(4, 0)))};
			pf = {1'($urandom), 2'($urandom_range(2, 0)), 2'($urandom), (i < 5 ? 3'(i) : 3'($urandom_range(4, 0)))};
			if (pf[4] && ((pf[2:0] == 3'b011 && pf[6:5] == 2'b01) || (pf[2:0] == 3'b100 && pf[6:5] == 2'b10)))
				pf[6:5] = ~pf[6:5];
			power(1'b1);
			wchk(`IX_OVR << 2, 32'(ov), `RESP_OK);
			wchk(`IX_FLOW << 2, 32'(fl), `RESP_OK);
			wchk(`IX_PFN << 2, 32'(pf), `RESP_OK);
			rchk(`IX_FLOW << 2, 32'(fl), `RESP_OK);
			chk(32'(ctl), 32'(want(8'h00, 16'h0000, 8'h00, 1'b0, link)));
			power(1'b0);
			lchk(1'b0);
		end
		$display("test settings done");
		ov = 8'h01;
		fl = 16'h0000;
		pf = 8'h00;
		power(1'b1);
		wchk(`IX_LOCK << 2, 32'h40, `RESP_OK);
		rchk(`IX_LOCK << 2, 32'h0, `RESP_OK);
		wchk(`IX_ARM << 2, 32'(`ARM_KEY), `RESP_OK);
		wchk(`IX_LOCK << 2, 32'h40, `RESP_OK);
		wchk(`A_COMMIT, 32'h1, `RESP_OK);
		rchk(`IX_LOCK << 2, 32'h40, `RESP_OK);
		wchk(`IX_LOCK << 2, 32'h40, `RESP_SLV);
		wchk(`IX_OVR << 2, 32'h01, `RESP_OK);
		rchk(`A_STATUS, 32'h0, `RESP_OK);
		power(1'b0);
		rchk(`A_STATUS, 32'h1, `RESP_OK);
		wchk(`IX_OVR << 2, 32'h02, `RESP_SLV);
		rchk(`IX_OVR << 2, 32'h01, `RESP_OK);
		lchk(1'b1);
		$display("test lock done");
		close_out;
	end

	// Cut a hung run short
	initial
	begin
		#200000;
		errors++;
		close_out;
	end
endmodule
